//--- hw/snslp_dev.sv
// Memory end: decodes serial-number read and the two low-power commands.
// Assumes link pins are asynchronous to clk and are sampled through three flops.
`default_nettype none
module snslp_dev
   import snslp_pkg::*;
#(
   parameter int DEEP_ENTRY_CYC = SNSLP_DEEP_ENTRY_CYC,
   parameter int DEEP_EXIT_CYC = SNSLP_DEEP_EXIT_CYC,
   parameter int WAKE_PULSE_CYC = SNSLP_WAKE_PULSE_CYC,
   parameter int LOW_ENTRY_CYC = SNSLP_LOW_ENTRY_CYC,
   parameter int LOW_EXIT_CYC = SNSLP_LOW_EXIT_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Link
   snslp_if.dev lnk,
   // User side: stored serial number, status
   input wire logic [63:0] sn_value,
   output logic asleep,
   output logic waking
);
   import snslp_pkg::*;

   typedef enum logic [5:0] {
      ST_ACTIVE = 6'b000001,  // Normal command decode
      ST_ENTER  = 6'b000010,  // Entry delay running
      ST_DEEP   = 6'b000100,  // Deep power-down
      ST_LOW    = 6'b001000,  // Lowest-power sleep
      ST_WAKE   = 6'b010000,  // Exit delay running
      ST_PULSE  = 6'b100000   // Measuring wake pulse width
   } snslp_state_type;

   ////////////////////////////////////////////////////////////////////
   // Three-flop sampling of link pins; for select and clock, second and third must agree
   logic [2:0] cs_sync_r, sck_sync_r, si_sync_r;
   logic cs_n_r, sck_r;
   always_ff @(posedge clk) begin
      if (srst) begin
         cs_sync_r <= 3'h7;
         sck_sync_r <= 3'h0;
         si_sync_r <= 3'h0;
      end else begin
         cs_sync_r <= {cs_sync_r[1:0], lnk.cs_n};
         sck_sync_r <= {sck_sync_r[1:0], lnk.sck};
         si_sync_r <= {si_sync_r[1:0], lnk.si};
      end
   end

   // Filtered levels update only when stages two and three agree
   wire cs_agree = (cs_sync_r[1] == cs_sync_r[2]);
   wire sck_agree = (sck_sync_r[1] == sck_sync_r[2]);
   always_ff @(posedge clk) begin
      if (srst) begin
         cs_n_r <= 1'b1;
         sck_r <= 1'b0;
      end else begin
         if (cs_agree) begin
            cs_n_r <= cs_sync_r[2];
         end
         if (sck_agree) begin
            sck_r <= sck_sync_r[2];
         end
      end
   end

   wire cs_fall = cs_agree && !cs_sync_r[2] && cs_n_r;
   wire cs_rise = cs_agree && cs_sync_r[2] && !cs_n_r;
   wire sck_rise = sck_agree && sck_sync_r[2] && !sck_r && !cs_n_r;
   wire sck_fall = sck_agree && !sck_sync_r[2] && sck_r && !cs_n_r;

   ////////////////////////////////////////////////////////////////////
   // Frame state
   snslp_state_type state_r, state_nxt;
   logic [7:0] shift_r;        // Incoming opcode bits
   logic [3:0] bit_cnt_r;      // Bits received, saturates at 8
   logic [7:0] opcode_r;       // Latched opcode of this frame
   logic reading_r;            // Serial-number read in progress
   logic [2:0] byte_idx_r;     // Byte being sent
   logic [2:0] out_bit_r;      // Bit within byte, MSb first
   logic so_r;                 // Output bit register
   logic go_deep_r;            // Target of pending entry
   logic [15:0] cnt_r;         // Delay counter

   wire active = (state_r == ST_ACTIVE);
   wire opcode_done = active && sck_rise && (bit_cnt_r == 4'h7);
   wire [7:0] op_next = {shift_r[6:0], si_sync_r[2]};
   wire [7:0] sn_byte = sn_value[{byte_idx_r, 3'h0} +: 8];
   wire cnt_zero = (cnt_r == 16'h0000);

   // Serial shifting: only in the active state, sleep ignores the pins
   always_ff @(posedge clk) begin
      if (srst || !active || cs_n_r) begin
         shift_r <= 8'h00;
         bit_cnt_r <= 4'h0;
         reading_r <= 1'b0;
         byte_idx_r <= 3'h0;
         out_bit_r <= 3'h7;
         if (srst) begin
            opcode_r <= 8'h00;
         end else if (cs_fall) begin
            opcode_r <= 8'h00;
         end
      end else begin
         if (sck_rise && bit_cnt_r < 4'h8) begin
            shift_r <= op_next;
            bit_cnt_r <= bit_cnt_r + 4'h1;
         end
         if (opcode_done) begin
            opcode_r <= op_next;
            reading_r <= (op_next == SNSLP_OP_SN_READ);
         end
         if (reading_r && sck_fall) begin
            out_bit_r <= out_bit_r - 3'h1;
            if (out_bit_r == 3'h0) begin
               byte_idx_r <= byte_idx_r + 3'h1;  // wraps 7 to 0
            end
         end
      end
   end

   // Output bit launched on falling link edge, mode 0
   always_ff @(posedge clk) begin
      if (srst) begin
         so_r <= 1'b0;
      end else if (reading_r && sck_fall) begin
         so_r <= sn_byte[out_bit_r];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Power state machine
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_ACTIVE: begin
            if (cs_rise && (opcode_r == SNSLP_OP_DEEP_SLEEP
                            || opcode_r == SNSLP_OP_LOW_SLEEP)) begin
               state_nxt = ST_ENTER;
            end
         end
         ST_ENTER: begin
            if (cnt_zero) begin
               state_nxt = go_deep_r ? ST_DEEP : ST_LOW;
            end
         end
         ST_DEEP: begin
            if (cs_fall) begin
               state_nxt = ST_PULSE;
            end
         end
         ST_PULSE: begin
            // Pulse must last the wake width; a short one is discarded
            if (cs_rise) begin
               state_nxt = cnt_zero ? ST_WAKE : ST_DEEP;
            end else if (cnt_zero) begin
               state_nxt = ST_WAKE;
            end
         end
         ST_LOW: begin
            if (cs_fall) begin
               state_nxt = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (cnt_zero) begin
               state_nxt = ST_ACTIVE;
            end
         end
         default: state_nxt = ST_ACTIVE;
      endcase
   end

   // State, target and delay counter
   always_ff @(posedge clk) begin
      if (srst) begin
         state_r <= ST_ACTIVE;
         go_deep_r <= 1'b0;
         cnt_r <= 16'h0000;
      end else begin
         state_r <= state_nxt;
         if (state_nxt != state_r) begin
            unique case (state_nxt)
               ST_ENTER: begin
                  go_deep_r <= (opcode_r == SNSLP_OP_DEEP_SLEEP);
                  cnt_r <= (opcode_r == SNSLP_OP_DEEP_SLEEP)
                           ? 16'(DEEP_ENTRY_CYC - 1) : 16'(LOW_ENTRY_CYC - 1);
               end
               ST_PULSE: cnt_r <= 16'(WAKE_PULSE_CYC - 1);
               ST_WAKE: cnt_r <= go_deep_r ? 16'(DEEP_EXIT_CYC - 1)
                                           : 16'(LOW_EXIT_CYC - 1);
               default: cnt_r <= 16'h0000;
            endcase
         end else if (!cnt_zero) begin
            cnt_r <= cnt_r - 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Pins and status; wakeup traffic is dropped since decode is idle
   assign lnk.so_o = so_r;
   assign lnk.so_oe_n = !(active && reading_r && !cs_n_r);
   assign asleep = (state_r == ST_DEEP) || (state_r == ST_LOW) || (state_r == ST_PULSE);
   assign waking = (state_r == ST_WAKE);
endmodule : snslp_dev
`default_nettype wire

//--- hw/snslp_host.sv
// Bus-master end: runs serial-number reads and low-power commands.
// Assumes the device samples on rising link edges; link clock made here by divider.
`default_nettype none
module snslp_host
   import snslp_pkg::*;
#(
   parameter int HALF_CYC = SNSLP_SCK_HALF_CYC,
   parameter int WAKE_HOLD_CYC = SNSLP_WAKE_PULSE_CYC + 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Link
   snslp_if.host lnk,
   // Command port
   input wire logic cmd_valid,
   input wire logic [1:0] cmd_code,
   input wire logic [3:0] cmd_len,  // Bytes to read, 1..15
   output logic cmd_ready,
   // Read data
   output logic rd_valid,
   output logic [7:0] rd_data
);
   import snslp_pkg::*;

   typedef enum logic [3:0] {
      H_IDLE = 4'b0001,  // Waiting
      H_SHIFT = 4'b0010, // Clocking bits
      H_HOLD = 4'b0100,  // Select held low for wake
      H_GAP = 4'b1000    // Select high gap
   } snslp_hstate_type;

   snslp_hstate_type st_r;
   logic [7:0] div_r;
   logic sck_r, cs_n_r, si_r;
   logic [7:0] tx_r, rx_r;
   logic [2:0] bit_r;
   logic [4:0] bytes_r;   // Bytes left after opcode
   logic rd_valid_r;
   logic [7:0] rd_data_r;
   logic [2:0] so_s_r;
   logic data_r;          // Opcode sent; bytes from here on are data

   wire tick = (div_r == 8'(HALF_CYC - 1));
   wire [7:0] op_sel = (cmd_code == SNSLP_HCMD_SN_READ) ? SNSLP_OP_SN_READ
                     : (cmd_code == SNSLP_HCMD_DEEP) ? SNSLP_OP_DEEP_SLEEP
                     : SNSLP_OP_LOW_SLEEP;
   wire so_ok = (so_s_r[1] == so_s_r[2]);
   // Returned bits are taken at falling link edges: the device launches a bit on a
   // fall and the two three-flop paths delay it by about seven cycles, so the next
   // fall is the first edge at which it has settled here
   wire [7:0] rx_nxt = {rx_r[6:0], so_ok ? so_s_r[2] : rx_r[0]};

   ////////////////////////////////////////////////////////////////////
   // Sample returning data through three flops
   always_ff @(posedge clk) begin
      if (srst) begin
         so_s_r <= 3'h0;
      end else begin
         so_s_r <= {so_s_r[1:0], lnk.so_o};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Sequencer
   always_ff @(posedge clk) begin
      if (srst) begin
         st_r <= H_IDLE;
         div_r <= 8'h00;
         sck_r <= 1'b0;
         cs_n_r <= 1'b1;
         si_r <= 1'b0;
         tx_r <= 8'h00;
         rx_r <= 8'h00;
         bit_r <= 3'h0;
         bytes_r <= 5'h00;
         rd_valid_r <= 1'b0;
         rd_data_r <= 8'h00;
         data_r <= 1'b0;
      end else begin
         rd_valid_r <= 1'b0;
         div_r <= tick ? 8'h00 : div_r + 8'h01;
         unique case (st_r)
            H_IDLE: begin
               div_r <= 8'h00;
               data_r <= 1'b0;
               if (cmd_valid && cmd_code == SNSLP_HCMD_WAKE) begin
                  cs_n_r <= 1'b0;  // Select-only wake pulse
                  bytes_r <= 5'h00;  // Counts ticks of the pulse
                  st_r <= H_HOLD;
               end else if (cmd_valid) begin
                  cs_n_r <= 1'b0;
                  tx_r <= {op_sel[6:0], 1'b0};
                  si_r <= op_sel[7];
                  bit_r <= 3'h7;
                  bytes_r <= (cmd_code == SNSLP_HCMD_SN_READ) ? {1'b0, cmd_len} : 5'h00;
                  st_r <= H_SHIFT;
               end
            end
            H_SHIFT: begin
               if (tick && !sck_r) begin
                  sck_r <= 1'b1;
               end else if (tick) begin
                  sck_r <= 1'b0;
                  si_r <= tx_r[7];
                  tx_r <= {tx_r[6:0], 1'b0};
                  bit_r <= bit_r - 3'h1;
                  rx_r <= rx_nxt;
                  if (bit_r == 3'h0) begin
                     // Byte boundary: hand over the byte unless it was the opcode
                     rd_valid_r <= data_r;
                     rd_data_r <= rx_nxt;
                     data_r <= 1'b1;
                     if (bytes_r == 5'h00) begin
                        cs_n_r <= 1'b1;
                        st_r <= H_GAP;
                     end else begin
                        bytes_r <= bytes_r - 5'h01;
                     end
                  end
               end
            end
            H_HOLD: begin
               if (tick) begin
                  bytes_r <= bytes_r + 5'h01;
                  if (bytes_r == 5'(WAKE_HOLD_CYC / HALF_CYC)) begin
                     cs_n_r <= 1'b1;
                     bytes_r <= 5'h00;
                     st_r <= H_GAP;
                  end
               end
            end
            H_GAP: begin
               if (tick) begin
                  st_r <= H_IDLE;
               end
            end
            default: st_r <= H_IDLE;
         endcase
      end
   end

   // Every byte clocked after the opcode is a data byte
   assign cmd_ready = (st_r == H_IDLE);  // caller waits out exit delay
   assign rd_valid = rd_valid_r;
   assign rd_data = rd_data_r;
   assign lnk.cs_n = cs_n_r;
   assign lnk.sck = sck_r;
   assign lnk.si = si_r;
endmodule : snslp_host
`default_nettype wire

//--- hw/snslp_if.sv
// SPI link between the memory end and the bus-master end.
// Assumes the bench resolves the serial output from its enable (low enable = drive).
`default_nettype none
interface snslp_if;
   logic cs_n;     // Chip select, active low, from host
   logic sck;      // Link clock from host
   logic si;       // Serial data host to device
   logic so_o;     // Device serial output value
   logic so_oe_n;  // Device output enable, low while driving
   modport dev (input cs_n, input sck, input si, output so_o, output so_oe_n);
   modport host (output cs_n, output sck, output si, input so_o, input so_oe_n);
endinterface : snslp_if
`default_nettype wire

//--- hw/snslp_pkg.sv
// Shared constants for the serial-number read and low-power command block.
// Assumes a 20 MHz system clock on both ends and SPI mode 0 on the link.
`default_nettype none
package snslp_pkg;
   // Opcodes
   localparam logic [7:0] SNSLP_OP_SN_READ = 8'hC3;
   localparam logic [7:0] SNSLP_OP_DEEP_SLEEP = 8'hBA;
   localparam logic [7:0] SNSLP_OP_LOW_SLEEP = 8'hB9;
   // Serial-number space
   localparam int SNSLP_SN_BYTES = 8;
   localparam logic [63:0] SNSLP_SN_RESET = 64'h0000_0000_0000_0000;
   // System clock
   localparam int SNSLP_CLK_NS = 50;
   // Delays in ns (no printed values; plain defaults)
   localparam int SNSLP_DEEP_ENTRY_NS = 3000;
   localparam int SNSLP_DEEP_EXIT_NS = 10000;
   localparam int SNSLP_WAKE_PULSE_NS = 450;
   localparam int SNSLP_LOW_ENTRY_NS = 3000;
   localparam int SNSLP_LOW_EXIT_NS = 50000;
   // Cycle counts: least times round up, longest times round down
   localparam int SNSLP_DEEP_ENTRY_CYC = (SNSLP_DEEP_ENTRY_NS + SNSLP_CLK_NS - 1) / SNSLP_CLK_NS;
   localparam int SNSLP_DEEP_EXIT_CYC = SNSLP_DEEP_EXIT_NS / SNSLP_CLK_NS;
   localparam int SNSLP_WAKE_PULSE_CYC = (SNSLP_WAKE_PULSE_NS + SNSLP_CLK_NS - 1) / SNSLP_CLK_NS;
   localparam int SNSLP_LOW_ENTRY_CYC = (SNSLP_LOW_ENTRY_NS + SNSLP_CLK_NS - 1) / SNSLP_CLK_NS;
   localparam int SNSLP_LOW_EXIT_CYC = SNSLP_LOW_EXIT_NS / SNSLP_CLK_NS;
   // Host link clock divider: half period in system cycles (400 ns link period)
   localparam int SNSLP_SCK_HALF_CYC = 4;
   // Host command codes
   localparam logic [1:0] SNSLP_HCMD_SN_READ = 2'h0;
   localparam logic [1:0] SNSLP_HCMD_DEEP = 2'h1;
   localparam logic [1:0] SNSLP_HCMD_LOW = 2'h2;
   localparam logic [1:0] SNSLP_HCMD_WAKE = 2'h3;
endpackage : snslp_pkg
`default_nettype wire

//--- tb/snslp_checker.sv
// Checker for the link between the memory end and the bus-master end.
// Assumes the bench feeds it the interface signals and the memory end's status.
`default_nettype none
module snslp_checker #(
   parameter int ENTRY_MIN = 20,  // Shorter of the two entry delays
   parameter int EXIT_MIN = 40,   // Shorter of the two exit delays
   parameter int EXIT_MAX = 300   // Longer of the two exit delays
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Link
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic so_o,
   input wire logic so_oe_n,
   // Status
   input wire logic asleep,
   input wire logic waking
);
   ////////////////////////////////////////////////////////////////////////////////
   logic [15:0] hi_cnt_r;    // Cycles with select high, saturating
   logic [15:0] wk_cnt_r;    // Cycles spent waking
   logic [15:0] hi_cnt_nxt;
   logic [15:0] wk_cnt_nxt;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // Saturate so a long idle stretch cannot wrap to a small count
   assign hi_cnt_nxt = !cs_n ? 16'h0 : (&hi_cnt_r ? hi_cnt_r : hi_cnt_r + 16'h1);
   assign wk_cnt_nxt = waking ? wk_cnt_r + 16'h1 : 16'h0;
   // Counter registers
   always_ff @(posedge clk) begin
      if (srst) begin
         hi_cnt_r <= 16'h0;
         wk_cnt_r <= 16'h0;
      end else begin
         hi_cnt_r <= hi_cnt_nxt;
         wk_cnt_r <= wk_cnt_nxt;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   chk_float_asleep: assert property (asleep |-> so_oe_n)
      else $error("output driven while asleep");
   chk_float_waking: assert property (waking |-> so_oe_n)
      else $error("output driven while waking");
   chk_float_desel: assert property (cs_n [*6] |-> so_oe_n)
      else $error("output driven while deselected");
   chk_entry_delay: assert property ($rose(asleep) |-> hi_cnt_r >= ENTRY_MIN)
      else $error("sleep entered too early");
   chk_wake_cause: assert property ($rose(waking) |-> $past(asleep))
      else $error("wakeup without sleep");
   chk_wake_max: assert property (waking |-> wk_cnt_r <= EXIT_MAX)
      else $error("wakeup too long");
   chk_wake_min: assert property ($fell(waking) |-> wk_cnt_r >= EXIT_MIN - 1)
      else $error("wakeup too short");
   chk_sleep_holds: assert property ((asleep && cs_n) [*6] |=> asleep || waking)
      else $error("sleep left without select");
   chk_sck_idle: assert property (cs_n [*3] |-> !sck)
      else $error("link clock runs while deselected");
endmodule : snslp_checker
`default_nettype wire

//--- tb/snslp_tb.sv
// Testbench: host end drives the memory end through the shared link.
// Assumes both ends run on one 20 MHz clock; the bench drives the command port.
`default_nettype none
module snslp_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import snslp_pkg::*;
   ////////////////////////////////////////////////////////////////////////////////
   localparam int DEEP_IN = 20;   // Shortened delays keep the run brief
   localparam int LOW_IN = 24;
   localparam int PULSE = 6;
   localparam int DEEP_OUT = 40;
   localparam int LOW_OUT = 300;
   localparam logic [63:0] SN = 64'hF7E6_D5C4_B3A2_9180;  // Distinct bytes
   logic clk;
   logic srst;
   logic cmd_valid;
   logic [1:0] cmd_code;
   logic [3:0] cmd_len;
   logic cmd_ready;
   logic rd_valid;
   logic [7:0] rd_data;
   logic [63:0] sn_value;
   logic asleep;
   logic waking;
   logic [7:0] op_sh;         // Opcode seen on the data-in line
   logic [7:0] rx_sh;         // Byte being gathered from the data-out line
   logic [7:0] rx_q[$];       // Bytes gathered so far
   logic [7:0] hq[$];         // Bytes handed over by the host end
   logic seen_wake;           // Sticky: wakeup was observed
   logic sck_q;               // Link clock one system cycle back
   logic cs_q;                // Select one system cycle back
   int falls;
   int n_fail;
   int checked;
   ////////////////////////////////////////////////////////////////////////////////
   snslp_if lnk_if();
   wire logic [2:0] st = {waking, asleep, cmd_ready};
   // Floating output reads as unknown so it can never match
   wire logic so_bit = (lnk_if.so_oe_n === 1'b0) ? lnk_if.so_o : 1'bx;
   snslp_dev #(.DEEP_ENTRY_CYC(DEEP_IN), .DEEP_EXIT_CYC(DEEP_OUT), .WAKE_PULSE_CYC(PULSE),
      .LOW_ENTRY_CYC(LOW_IN), .LOW_EXIT_CYC(LOW_OUT)) snslp_dev_inst (.clk(clk), .srst(srst),
      .lnk(lnk_if), .sn_value(sn_value), .asleep(asleep), .waking(waking));
   snslp_host #(.WAKE_HOLD_CYC(PULSE + 2)) snslp_host_inst (.clk(clk), .srst(srst),
      .lnk(lnk_if), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_len(cmd_len),
      .cmd_ready(cmd_ready), .rd_valid(rd_valid), .rd_data(rd_data));
   snslp_checker #(.ENTRY_MIN(DEEP_IN), .EXIT_MIN(DEEP_OUT), .EXIT_MAX(LOW_OUT))
      snslp_checker_inst (.clk(clk), .srst(srst), .cs_n(lnk_if.cs_n), .sck(lnk_if.sck),
      .si(lnk_if.si), .so_o(lnk_if.so_o), .so_oe_n(lnk_if.so_oe_n), .asleep(asleep),
      .waking(waking));
   ////////////////////////////////////////////////////////////////////////////////
   // Clock
   always #25 clk = ~clk;
   // Link edges are found one system cycle late, against the select level they met;
   // watching the pins directly would race select against the last falling edge
   always @(posedge clk) begin
      sck_q <= lnk_if.sck;
      cs_q <= lnk_if.cs_n;
      // Opcode bits are taken on rising link edges, before the eighth fall
      if (cs_q === 1'b0 && sck_q === 1'b0 && lnk_if.sck === 1'b1 && falls < 8) begin
         op_sh = {op_sh[6:0], lnk_if.si};
      end
      // Data bits are taken one link period after they appear, at the next fall
      if (cs_q === 1'b0 && sck_q === 1'b1 && lnk_if.sck === 1'b0) begin
         falls++;
         if (falls > 8) begin
            rx_sh = {rx_sh[6:0], so_bit};
            if ((falls - 8) % 8 == 0) begin
               rx_q.push_back(rx_sh);
            end
         end
      end
      // Bytes handed over on the host end's command side
      if (rd_valid === 1'b1) begin
         hq.push_back(rd_data);
      end
   end
   // Remember a wakeup even when it ends inside a long command
   always @(posedge clk) begin
      if (waking === 1'b1) begin
         seen_wake <= 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic results();
      if (n_fail == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : results
   // One comparison
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // Bounded wait for one status bit
   task automatic wait_bit(input int b, input logic v, input int lim);
      for (int i = 0; i < lim; i++) begin
         @(posedge clk);
         if (st[b] === v) begin
            return;
         end
      end
      n_fail++;
      results();
   endtask : wait_bit
   // Issue one host command and wait until the host is idle again
   task automatic run(input logic [1:0] code, input logic [3:0] len);
      cmd_code <= code;
      cmd_len <= len;
      cmd_valid <= 1'b1;
      wait_bit(0, 1'b1, 100);
      cmd_valid <= 1'b0;
      repeat (2) @(posedge clk);
      wait_bit(0, 1'b1, 5000);
   endtask : run
   // Read n bytes and compare opcode and bytes on the wire
   task automatic read_sn(input int n);
      falls = 0;
      rx_q.delete();
      hq.delete();
      run(SNSLP_HCMD_SN_READ, 4'(n));
      chk(op_sh, SNSLP_OP_SN_READ);
      chk(rx_q.size(), n);
      chk(hq.size(), n);
      for (int i = 0; i < n; i++) begin
         chk(rx_q[i], SN[8 * (i % 8) +: 8]);
         chk(hq[i], SN[8 * (i % 8) +: 8]);
      end
   endtask : read_sn
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence: plain read, then deep sleep with each wake method, then low sleep woken by a read
   initial begin
      clk = 1'b0;
      srst = 1'b1;
      cmd_valid = 1'b0;
      cmd_code = 2'h0;
      cmd_len = 4'h0;
      sn_value = SN;
      seen_wake = 1'b0;
      falls = 0;
      n_fail = 0;
      checked = 0;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      read_sn(10);
      for (int k = 0; k < 3; k++) begin
         run((k == 2) ? SNSLP_HCMD_LOW : SNSLP_HCMD_DEEP, 4'h0);
         wait_bit(1, 1'b1, 200);
         chk(asleep, 1'b1);
         chk(lnk_if.so_oe_n, 1'b1);
         seen_wake = 1'b0;
         run((k == 0) ? SNSLP_HCMD_WAKE : SNSLP_HCMD_SN_READ, 4'h1);
         // Select is sampled through three flops, so wakeup shows a few cycles late
         repeat (6) @(posedge clk);
         wait_bit(2, 1'b0, 1000);
         chk(seen_wake, 1'b1);
         chk(asleep, 1'b0);
         read_sn(9);
      end
      results();
   end
endmodule : snslp_tb
`default_nettype wire
